// >>> core/voice_pcm_serial_port.sv
`timescale 1ns/1ps
// Contract
// - One mono voice channel at 8 kHz runs both ways, paced by the bit clock.
// - Of the two ports only the one chosen by configuration is ever active.
// - As master the bit clock is driven out, as slave it is taken in.
// - Slave clocking is honoured on port one only; port two is always master.
// - The frame strobe stands one bit period ahead of the sample MSB.
// - Samples are two's complement and travel MSB first.
// - In combined mode uplink comes from the serial port only, downlink to both.
// - A frame is seventeen bit periods: one strobe slot and sixteen data bits.
// - The strobe is sampled on each falling edge; MSB goes out at next rise.
// - With strobe low the rest shift out per rise, then the next word reloads.
// - Each word is 16 bits from 13-bit voice with the three low bits zero.
module voice_pcm_serial_port #(
	parameter int HALF = voice_pcm_pkg::HALF_CYC
) (
	// System clock domain
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire voice_pcm_pkg::cfg_s cfg_i,
	// Voice streams
	input wire voice_pcm_pkg::sample_t dl_word_i,
	input wire logic dl_valid_i,
	input wire voice_pcm_pkg::sample_t mic_word_i,
	input wire logic mic_valid_i,
	output voice_pcm_pkg::sample_t ul_word_o,
	output logic ul_valid_o,
	output voice_pcm_pkg::sample_t ana_word_o,
	output logic ana_valid_o,
	// Link clock
	input wire logic link_clk_i,
	// Port one pins
	input wire logic p1_clk_i,
	output logic p1_clk_o,
	output logic p1_clk_oe_o,
	input wire logic p1_sync_i,
	output logic p1_sync_o,
	output logic p1_sync_oe_o,
	input wire logic p1_rx_i,
	output logic p1_tx_o,
	// Port two pins
	output logic p2_clk_o,
	output logic p2_sync_o,
	input wire logic p2_rx_i,
	output logic p2_tx_o
);

	////////////////////////////////////////////////////////////////////////
	// Link domain reset and enable
	logic [1:0] lrst_q;
	logic [1:0] lce_q;
	logic lrst;
	logic lce;

	// Plain two-flop carry of reset and enable into the link domain
	always_ff @(posedge link_clk_i)
	begin
		lrst_q <= {lrst_q[0], rst_i};
		lce_q <= {lce_q[0], ce_i};
	end
	assign lrst = lrst_q[1];
	assign lce = lce_q[1];

	////////////////////////////////////////////////////////////////////////
	// Configuration and pins into the link domain
	voice_pcm_pkg::cfg_s cfg_l;
	logic [3:0] pin_l;
	logic active;
	logic eff_slave;
	logic sel1;
	logic sel2;

	sync_bits #(.W(voice_pcm_pkg::CFG_W)) u_cfg_sync (
		.clk_i(link_clk_i),
		.rst_i(lrst),
		.ce_i(lce),
		.d_i(cfg_i),
		.q_o(cfg_l)
	);

	sync_bits #(.W(4)) u_pin_sync (
		.clk_i(link_clk_i),
		.rst_i(lrst),
		.ce_i(lce),
		.d_i({p2_rx_i, p1_rx_i, p1_sync_i, p1_clk_i}),
		.q_o(pin_l)
	);

	// Port choice and clocking role
	assign active = voice_pcm_pkg::dvi_on(cfg_l.route);
	assign eff_slave = cfg_l.slave & ~cfg_l.port2;
	assign sel1 = active & ~cfg_l.port2;
	assign sel2 = active & cfg_l.port2;

	////////////////////////////////////////////////////////////////////////
	// Master bit clock divider
	logic [voice_pcm_pkg::DIV_W-1:0] div_q;
	logic mclk_q;
	logic tick;

	assign tick = (div_q == voice_pcm_pkg::DIV_W'(HALF - 1));

	// 136 kHz from the link clock, rounded to whole half periods
	always_ff @(posedge link_clk_i)
	begin
		if (lrst)
		begin
			div_q <= '0;
			mclk_q <= 1'b0;
		end
		else if (lce)
		begin
			div_q <= tick ? '0 : div_q + 1'b1;
			if (tick)
				mclk_q <= ~mclk_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit clock edges from either source
	logic sclk_prev_q;
	logic rise;
	logic fall;

	// Slave edge detect looks at the settled copy only
	always_ff @(posedge link_clk_i)
	begin
		if (lrst)
			sclk_prev_q <= 1'b0;
		else if (lce)
			sclk_prev_q <= pin_l[0];
	end

	assign rise = active & (eff_slave ? (pin_l[0] & ~sclk_prev_q)
		: (tick & ~mclk_q));
	assign fall = active & (eff_slave ? (~pin_l[0] & sclk_prev_q)
		: (tick & mclk_q));

	////////////////////////////////////////////////////////////////////////
	// Master frame slots and strobe
	logic [voice_pcm_pkg::SLOT_W-1:0] slot_q;
	logic mstrobe_q;
	logic strobe_in;

	// Strobe rises with slot zero, one period before the MSB
	always_ff @(posedge link_clk_i)
	begin
		if (lrst || !active)
		begin
			slot_q <= voice_pcm_pkg::SLOT_LAST;
			mstrobe_q <= 1'b0;
		end
		else if (lce && rise && !eff_slave)
		begin
			slot_q <= (slot_q == voice_pcm_pkg::SLOT_LAST)
				? voice_pcm_pkg::SLOT_FIRST : slot_q + 1'b1;
			mstrobe_q <= (slot_q == voice_pcm_pkg::SLOT_LAST);
		end
	end

	assign strobe_in = eff_slave ? pin_l[1] : mstrobe_q;

	////////////////////////////////////////////////////////////////////////
	// Downlink words into the transmit buffer
	voice_pcm_pkg::sample_t dl_l;
	logic dl_l_valid;
	voice_pcm_pkg::sample_t tx_buf_q;

	word_xfer #(.W(voice_pcm_pkg::WORD_BITS)) u_dl_xfer (
		.src_clk_i(clock_i),
		.src_rst_i(rst_i),
		.src_ce_i(ce_i),
		.src_valid_i(dl_valid_i & voice_pcm_pkg::dvi_on(cfg_i.route)),
		.src_data_i(dl_word_i),
		.dst_clk_i(link_clk_i),
		.dst_rst_i(lrst),
		.dst_ce_i(lce),
		.dst_valid_o(dl_l_valid),
		.dst_data_o(dl_l)
	);

	// Last word wins; a missing word repeats the previous one
	always_ff @(posedge link_clk_i)
	begin
		if (lrst)
			tx_buf_q <= '0;
		else if (lce && dl_l_valid)
			tx_buf_q <= voice_pcm_pkg::pad_clear(dl_l);
	end

	////////////////////////////////////////////////////////////////////////
	// Strobe capture and transmit shifter
	logic seen_q;
	logic [voice_pcm_pkg::SLOT_W-1:0] bit_cnt_q;
	voice_pcm_pkg::sample_t tx_sh_q;
	logic tx_q;

	// Strobe level as seen at the last falling edge
	always_ff @(posedge link_clk_i)
	begin
		if (lrst || !active)
			seen_q <= 1'b0;
		else if (lce && fall)
			seen_q <= strobe_in;
	end

	// MSB after the strobe, then one bit per rise while the strobe is low
	always_ff @(posedge link_clk_i)
	begin
		if (lrst || !active)
		begin
			bit_cnt_q <= '0;
			tx_sh_q <= '0;
			tx_q <= 1'b0;
		end
		else if (lce && rise)
		begin
			if (seen_q)
			begin
				tx_q <= tx_sh_q[voice_pcm_pkg::WORD_BITS-1];
				tx_sh_q <= tx_sh_q << 1;
				bit_cnt_q <= voice_pcm_pkg::BIT_CNT_MSB;
			end
			else if (bit_cnt_q != '0)
			begin
				tx_q <= tx_sh_q[voice_pcm_pkg::WORD_BITS-1];
				bit_cnt_q <= bit_cnt_q - 1'b1;
				if (bit_cnt_q == voice_pcm_pkg::CNT_ONE)
					tx_sh_q <= tx_buf_q;
				else
					tx_sh_q <= tx_sh_q << 1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive shifter
	logic rx_bit;
	logic [voice_pcm_pkg::SLOT_W-1:0] rx_cnt_q;
	voice_pcm_pkg::sample_t rx_sh_q;
	voice_pcm_pkg::sample_t rx_word_q;
	logic rx_done_q;

	// Unselected port's receive line never reaches the shifter
	assign rx_bit = sel2 ? pin_l[3] : (sel1 & pin_l[2]);

	// Bits taken on falling edges, MSB first
	always_ff @(posedge link_clk_i)
	begin
		if (lrst || !active)
		begin
			rx_cnt_q <= '0;
			rx_sh_q <= '0;
			rx_word_q <= '0;
			rx_done_q <= 1'b0;
		end
		else if (lce)
		begin
			rx_done_q <= 1'b0;
			if (rise && seen_q)
				rx_cnt_q <= voice_pcm_pkg::RX_CNT_FULL;
			else if (fall && rx_cnt_q != '0)
			begin
				rx_sh_q <= {rx_sh_q[voice_pcm_pkg::WORD_BITS-2:0], rx_bit};
				rx_cnt_q <= rx_cnt_q - 1'b1;
				if (rx_cnt_q == voice_pcm_pkg::CNT_ONE)
				begin
					rx_word_q <= voice_pcm_pkg::pad_clear(
						{rx_sh_q[voice_pcm_pkg::WORD_BITS-2:0], rx_bit});
					rx_done_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered and quiet when not selected
	always_ff @(posedge link_clk_i)
	begin
		if (lrst)
		begin
			p1_clk_o <= 1'b0;
			p1_clk_oe_o <= 1'b0;
			p1_sync_o <= 1'b0;
			p1_sync_oe_o <= 1'b0;
			p1_tx_o <= 1'b0;
			p2_clk_o <= 1'b0;
			p2_sync_o <= 1'b0;
			p2_tx_o <= 1'b0;
		end
		else if (lce)
		begin
			p1_clk_o <= sel1 & ~eff_slave & mclk_q;
			p1_clk_oe_o <= sel1 & ~eff_slave;
			p1_sync_o <= sel1 & ~eff_slave & mstrobe_q;
			p1_sync_oe_o <= sel1 & ~eff_slave;
			p1_tx_o <= sel1 & tx_q;
			p2_clk_o <= sel2 & mclk_q;
			p2_sync_o <= sel2 & mstrobe_q;
			p2_tx_o <= sel2 & tx_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Uplink words back to the system domain
	voice_pcm_pkg::sample_t rx_s;
	logic rx_s_valid;

	word_xfer #(.W(voice_pcm_pkg::WORD_BITS)) u_ul_xfer (
		.src_clk_i(link_clk_i),
		.src_rst_i(lrst),
		.src_ce_i(lce),
		.src_valid_i(rx_done_q),
		.src_data_i(rx_word_q),
		.dst_clk_i(clock_i),
		.dst_rst_i(rst_i),
		.dst_ce_i(ce_i),
		.dst_valid_o(rx_s_valid),
		.dst_data_o(rx_s)
	);

	// Serial port replaces the microphone whenever it is on
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			ul_word_o <= '0;
			ul_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (voice_pcm_pkg::dvi_on(cfg_i.route))
			begin
				ul_valid_o <= rx_s_valid;
				if (rx_s_valid)
					ul_word_o <= rx_s;
			end
			else
			begin
				ul_valid_o <= mic_valid_i;
				if (mic_valid_i)
					ul_word_o <= mic_word_i;
			end
		end
		else
			ul_valid_o <= 1'b0;
	end

	// Downlink copy to the analog output
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			ana_word_o <= '0;
			ana_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ana_valid_o <= dl_valid_i & voice_pcm_pkg::ana_on(cfg_i.route);
			if (dl_valid_i)
				ana_word_o <= dl_word_i;
		end
		else
			ana_valid_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Either reset silences the link checks; the link reset copy is
	// unknown for its first two edges, so the system reset covers it
	logic chk_off;
	assign chk_off = rst_i | lrst;

	a_strobe_slot: assert property (@(posedge link_clk_i) disable iff (chk_off)
		mstrobe_q == (slot_q == voice_pcm_pkg::SLOT_FIRST))
		else $error("strobe outside slot zero");

	a_frame_wrap: assert property (@(posedge link_clk_i) disable iff (chk_off)
		(lce && rise && !eff_slave && slot_q == voice_pcm_pkg::SLOT_LAST)
		|=> (slot_q == voice_pcm_pkg::SLOT_FIRST || !active))
		else $error("frame not seventeen slots");

	a_divider_range: assert property (@(posedge link_clk_i) disable iff (chk_off)
		div_q < voice_pcm_pkg::DIV_W'(HALF))
		else $error("divider out of range");

	a_one_port: assert property (@(posedge link_clk_i) disable iff (chk_off)
		!((p1_clk_oe_o || p1_tx_o) && (p2_clk_o || p2_tx_o)))
		else $error("both ports active");

	a_port2_master: assert property (@(posedge link_clk_i) disable iff (chk_off)
		(lce && sel2) |=> !p1_clk_oe_o)
		else $error("port two let port one drive");

	a_idle_quiet: assert property (@(posedge link_clk_i) disable iff (chk_off)
		(!active && $past(!active)) |-> !(p1_clk_o || p1_clk_oe_o || p1_tx_o
		|| p1_sync_oe_o || p2_clk_o || p2_sync_o || p2_tx_o))
		else $error("idle port drives pins");

	a_msb_sync: assert property (@(posedge link_clk_i) disable iff (chk_off)
		(lce && active && rise && seen_q)
		|=> tx_q == $past(tx_sh_q[voice_pcm_pkg::WORD_BITS-1]))
		else $error("MSB not sent after strobe");

	a_tail_reload: assert property (@(posedge link_clk_i) disable iff (chk_off)
		(lce && active && rise && !seen_q && bit_cnt_q == voice_pcm_pkg::CNT_ONE)
		|=> tx_sh_q == $past(tx_buf_q))
		else $error("next word not reloaded");

	a_pad_zero: assert property (@(posedge link_clk_i) disable iff (chk_off)
		tx_buf_q[voice_pcm_pkg::PAD_BITS-1:0] == '0
		&& rx_word_q[voice_pcm_pkg::PAD_BITS-1:0] == '0)
		else $error("pad bits not zero");

	a_uplink_route: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && voice_pcm_pkg::dvi_on(cfg_i.route) && !rx_s_valid)
		|=> !ul_valid_o)
		else $error("microphone leaked to uplink");

	c_rx_word: cover property (@(posedge link_clk_i) disable iff (chk_off)
		rx_done_q);
	c_slave_frame: cover property (@(posedge link_clk_i) disable iff (chk_off)
		eff_slave && rise && seen_q);
	c_both_route: cover property (@(posedge clock_i) disable iff (rst_i)
		ana_valid_o && cfg_i.route == voice_pcm_pkg::ROUTE_BOTH);

endmodule : voice_pcm_serial_port

// >>> core/voice_pcm_pkg.sv
package voice_pcm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Framing and rates
	localparam int SAMPLE_HZ = 8000;
	localparam int FRAME_BITS = 17;
	localparam int WORD_BITS = 16;
	localparam int VOICE_BITS = 13;
	localparam int PAD_BITS = WORD_BITS - VOICE_BITS;
	localparam int SLOT_W = 5;
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h00;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h10;
	localparam logic [SLOT_W-1:0] BIT_CNT_MSB = 5'h0f;
	localparam logic [SLOT_W-1:0] RX_CNT_FULL = 5'h10;
	localparam logic [SLOT_W-1:0] CNT_ONE = 5'h01;

	// Link-side clock and bit clock divider (half period rounds down)
	localparam int LINK_CLK_HZ = 12_500_000;
	localparam int BIT_HZ = SAMPLE_HZ * FRAME_BITS;
	localparam int HALF_CYC = LINK_CLK_HZ / (2 * BIT_HZ);
	localparam int DIV_W = 8;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;

	////////////////////////////////////////////////////////////////////////
	// Audio route codes
	localparam logic [1:0] ROUTE_ANALOG = 2'h0;
	localparam logic [1:0] ROUTE_DIGITAL = 2'h1;
	localparam logic [1:0] ROUTE_BOTH = 2'h2;

	typedef logic [WORD_BITS-1:0] sample_t;

	// Port configuration, held steady by software while in use
	typedef struct packed {
		logic [1:0] route;
		logic port2;
		logic slave;
	} cfg_s;

	localparam int CFG_W = $bits(cfg_s);

	////////////////////////////////////////////////////////////////////////
	// Serial port in use for this route
	function automatic logic dvi_on(input logic [1:0] r);
		return (r == ROUTE_DIGITAL) || (r == ROUTE_BOTH);
	endfunction : dvi_on

	// Analog output in use for this route
	function automatic logic ana_on(input logic [1:0] r);
		return (r == ROUTE_ANALOG) || (r == ROUTE_BOTH);
	endfunction : ana_on

	// Keep the 13 voice bits, clear the pad
	function automatic sample_t pad_clear(input sample_t w);
		return {w[WORD_BITS-1:PAD_BITS], {PAD_BITS{1'b0}}};
	endfunction : pad_clear

endpackage : voice_pcm_pkg

// >>> core/sync_bits.sv
`timescale 1ns/1ps
// Three-stage synchroniser; output follows once stages two and three agree
module sync_bits #(
	parameter int W = 1
) (
	// Clocking
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Stage one is read by stage two only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else if (ce_i)
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Per bit agreement filters a single-cycle disagreement
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					q_o[g] <= 1'b0;
				else if (ce_i && (s2_q[g] == s3_q[g]))
					q_o[g] <= s3_q[g];
			end
		end
	endgenerate

endmodule : sync_bits

// >>> core/word_xfer.sv
`timescale 1ns/1ps
// Toggle handshake word crossing; one word per sample period is far below
// the crossing latency, so no return acknowledge is kept
module word_xfer #(
	parameter int W = 16
) (
	// Source domain
	input wire logic src_clk_i,
	input wire logic src_rst_i,
	input wire logic src_ce_i,
	input wire logic src_valid_i,
	input wire logic [W-1:0] src_data_i,
	// Destination domain
	input wire logic dst_clk_i,
	input wire logic dst_rst_i,
	input wire logic dst_ce_i,
	output logic dst_valid_o,
	output logic [W-1:0] dst_data_o
);

	logic tgl_q;
	logic [W-1:0] hold_q;
	logic t1_q;
	logic t2_q;
	logic t3_q;

	// Source holds the word steady while the toggle travels
	always_ff @(posedge src_clk_i)
	begin
		if (src_rst_i)
		begin
			tgl_q <= 1'b0;
			hold_q <= '0;
		end
		else if (src_ce_i && src_valid_i)
		begin
			tgl_q <= ~tgl_q;
			hold_q <= src_data_i;
		end
	end

	// Toggle synchroniser; first flop feeds only the second
	always_ff @(posedge dst_clk_i)
	begin
		if (dst_rst_i)
		begin
			t1_q <= 1'b0;
			t2_q <= 1'b0;
			t3_q <= 1'b0;
		end
		else if (dst_ce_i)
		begin
			t1_q <= tgl_q;
			t2_q <= t1_q;
			t3_q <= t2_q;
		end
	end

	// Capture once the toggle has settled
	always_ff @(posedge dst_clk_i)
	begin
		if (dst_rst_i)
		begin
			dst_valid_o <= 1'b0;
			dst_data_o <= '0;
		end
		else if (dst_ce_i)
		begin
			dst_valid_o <= t2_q ^ t3_q;
			if (t2_q ^ t3_q)
				dst_data_o <= hold_q;
		end
		else
			dst_valid_o <= 1'b0;
	end

endmodule : word_xfer

// >>> verification/pcm_codec_model.sv
`timescale 1ns/1ps
// Far-end codec: sends one word per frame, captures the word it receives
module pcm_codec_model (
	// Control
	input wire logic gen_i,
	input wire logic [15:0] send_i,
	// Line side
	input wire logic bclk_i,
	input wire logic sync_i,
	input wire logic tx_i,
	output logic bclk_o,
	output logic sync_o,
	output logic rx_o,
	// Last captured word and count of words
	output logic [15:0] got_o,
	output int got_n_o
);
	int slot;
	int rcnt;
	int tcnt;
	logic armed;
	logic [15:0] sh;

	initial
	begin
		{bclk_o, sync_o, rx_o, armed} = 4'h0;
		slot = 16;
		rcnt = 16;
		tcnt = 16;
		got_n_o = 0;
		got_o = 16'h0000;
		sh = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Slave bit clock, still when not generating; slow for the synchroniser
	always #1000 bclk_o = gen_i ? ~bclk_o : 1'b0;

	// Strobe owns slot 0 of 17, one bit period ahead of the MSB
	always @(posedge bclk_o)
	begin
		slot = (slot == 16) ? 0 : slot + 1;
		sync_o <= (slot == 0);
	end

	// Strobe high on a fall arms the word; then 16 bits captured
	always @(negedge bclk_i)
	begin
		if (sync_i === 1'b1)
		begin
			armed = 1'b1;
			tcnt = 0;
			rcnt = 0;
		end
		else if (armed && tcnt < 16)
		begin
			sh = {sh[14:0], tx_i};
			tcnt++;
			if (tcnt == 16)
			begin
				got_o = sh;
				got_n_o++;
			end
		end
	end

	// MSB first on rises; afterwards the line is not held at the last bit
	always @(posedge bclk_i)
	begin
		if (armed && rcnt < 16)
			rx_o = send_i[15 - rcnt];
		else
			rx_o = ~rx_o;
		rcnt++;
	end

endmodule : pcm_codec_model

// >>> verification/voice_pcm_serial_port_tb_top.sv
`timescale 1ns/1ps
module voice_pcm_serial_port_tb_top;
	logic clock_i = 1'b0;
	logic link_clk;
	logic rst;
	voice_pcm_pkg::cfg_s cfg;
	voice_pcm_pkg::sample_t dl_word, mic_word, ul_word, ana_word;
	logic dl_valid, mic_valid, ul_valid, ana_valid, gen;
	logic p1_clk, p1_clk_oe, p1_sync, p1_sync_oe, p1_tx;
	logic p2_clk, p2_sync, p2_tx, m_clk, m_sync, m_rx;
	logic p1_clkw, p1_syncw, pclk, psync, ptx;
	logic [15:0] send, got;
	int got_n, stray, checks, miscompares;

	always #12.5 clock_i = ~clock_i;

	// Link clock offset so edges never line up with the system clock
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #40 link_clk = ~link_clk;
	end

	// Wire levels from the core's enables, else the codec's drive; codec follows chosen port
	assign p1_clkw = p1_clk_oe ? p1_clk : m_clk;
	assign p1_syncw = p1_sync_oe ? p1_sync : m_sync;
	assign pclk = cfg.port2 ? p2_clk : p1_clkw;
	assign psync = cfg.port2 ? p2_sync : p1_syncw;
	assign ptx = cfg.port2 ? p2_tx : p1_tx;

	voice_pcm_serial_port #(.HALF(12)) uut (
		.clock_i(clock_i), .rst_i(rst), .ce_i(1'b1), .cfg_i(cfg),
		.dl_word_i(dl_word), .dl_valid_i(dl_valid),
		.mic_word_i(mic_word), .mic_valid_i(mic_valid),
		.ul_word_o(ul_word), .ul_valid_o(ul_valid),
		.ana_word_o(ana_word), .ana_valid_o(ana_valid),
		.link_clk_i(link_clk),
		.p1_clk_i(p1_clkw), .p1_clk_o(p1_clk), .p1_clk_oe_o(p1_clk_oe),
		.p1_sync_i(p1_syncw), .p1_sync_o(p1_sync),
		.p1_sync_oe_o(p1_sync_oe), .p1_rx_i(m_rx), .p1_tx_o(p1_tx),
		.p2_clk_o(p2_clk), .p2_sync_o(p2_sync), .p2_rx_i(m_rx),
		.p2_tx_o(p2_tx)
	);

	pcm_codec_model codec (
		.gen_i(gen), .send_i(send), .bclk_i(pclk), .sync_i(psync),
		.tx_i(ptx), .bclk_o(m_clk), .sync_o(m_sync), .rx_o(m_rx),
		.got_o(got), .got_n_o(got_n)
	);

	// Any activity on the port that is not selected
	always @(posedge clock_i)
		if ((cfg.port2 ? (p1_clk | p1_sync | p1_tx) :
			(p2_clk | p2_sync | p2_tx)) === 1'b1)
			stray++;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	// Config is static, so every scenario starts from a fresh reset; the
	// port choice moves only once the old port's pins are reset quiet
	task automatic start(input logic [1:0] r, input logic p2, input logic sl);
		@(posedge clock_i);
		rst <= 1'b1;
		repeat (16) @(posedge clock_i);
		cfg <= {r, p2, sl};
		gen <= sl & ~p2;
		repeat (4) @(posedge clock_i);
		rst <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask : start

	// One-cycle valid pulse; returns just after the answering edge
	task automatic put(input logic mic, input logic [15:0] w);
		@(posedge clock_i);
		if (mic)
		begin
			mic_word <= w;
			mic_valid <= 1'b1;
		end
		else
		begin
			dl_word <= w;
			dl_valid <= 1'b1;
		end
		@(posedge clock_i);
		mic_valid <= 1'b0;
		dl_valid <= 1'b0;
		#1;
	endtask : put

	// Bit clock rises from one strobe start to the next, and under strobe
	task automatic frame_shape();
		int rises, hi, n;
		logic seen, pc, ps;
		rises = 0;
		hi = 0;
		seen = 1'b0;
		pc = pclk;
		ps = psync;
		for (n = 0; n < 6000; n++)
		begin
			@(posedge clock_i);
			if (psync === 1'b1 && ps === 1'b0)
			begin
				if (seen)
					break;
				seen = 1'b1;
			end
			if (seen && pclk === 1'b1 && pc === 1'b0)
			begin
				rises++;
				hi += (psync === 1'b1);
			end
			{pc, ps} = {pclk, psync};
		end
		check(16'(rises), 16'h11);
		check(16'(hi), 16'h1);
	endtask : frame_shape

	task automatic wait_ul(input logic [15:0] exp);
		int n;
		n = 0;
		while (ul_valid !== 1'b1 && n < 4000)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		check(ul_word, exp);
	endtask : wait_ul

	// Words both ways; three frames let the new downlink word settle
	task automatic xfer(input logic [15:0] tw, input logic [15:0] rw);
		int n0, n;
		n = 0;
		send <= rw;
		// Words a few link clocks apart can merge in the crossing
		repeat (32) @(posedge clock_i);
		put(1'b0, tw);
		n0 = got_n;
		while (got_n < n0 + 3 && n < 6000)
		begin
			@(posedge clock_i);
			n++;
		end
		check(got, {tw[15:3], 3'h0});
		wait_ul({rw[15:3], 3'h0});
	endtask : xfer

	////////////////////////////////////////////////////////////////////////
	task automatic s_off();
		int bad;
		bad = 0;
		start(2'h3, 1'b0, 1'b1);
		repeat (2800)
		begin
			@(posedge clock_i);
			bad += ((ul_valid | p1_clk | p1_clk_oe | p1_sync | p1_sync_oe |
				p1_tx | p2_clk | p2_sync | p2_tx) !== 1'b0);
		end
		check(16'(bad), 16'h0);
	endtask : s_off

	task automatic s_analog();
		start(2'h0, 1'b0, 1'b0);
		put(1'b1, 16'h1238);
		check(ul_valid, 16'h1);
		check(ul_word, 16'h1238);
		put(1'b0, 16'hc0d8);
		check(ana_valid, 16'h1);
	endtask : s_analog

	task automatic s_master1();
		start(2'h1, 1'b0, 1'b0);
		frame_shape();
		check({p1_clk_oe, p1_sync_oe}, 16'h3);
		xfer(16'h8a5f, 16'h5b37);
	endtask : s_master1

	task automatic s_both();
		int n;
		n = 0;
		start(2'h2, 1'b0, 1'b0);
		put(1'b0, 16'h7ff8);
		check(ana_valid, 16'h1);
		check(ana_word, 16'h7ff8);
		xfer(16'h7ff8, 16'h9e6d);
		put(1'b1, 16'h0aa8);
		repeat (4)
		begin
			n += (ul_valid !== 1'b0);
			@(posedge clock_i);
			#1;
		end
		check(16'(n), 16'h0);
	endtask : s_both

	// Slave asked on port two still runs as master
	task automatic s_port2();
		start(2'h1, 1'b1, 1'b1);
		frame_shape();
		check({p1_clk_oe, p1_sync_oe}, 16'h0);
		xfer(16'hf00f, 16'h8001);
	endtask : s_port2

	task automatic s_slave();
		start(2'h1, 1'b0, 1'b1);
		check({p1_clk_oe, p1_sync_oe}, 16'h0);
		xfer(16'h3c3c, 16'he9b5);
	endtask : s_slave

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst, dl_valid, mic_valid, gen} = 4'h8;
		{dl_word, mic_word, send} = '0;
		cfg = '0;
		stray = 0;
		checks = 0;
		miscompares = 0;
		s_off();
		s_analog();
		s_master1();
		s_both();
		s_port2();
		s_slave();
		check(16'(stray), 16'h0);
		summarize();
	end

	// Hang guard, well past the longest scenario sequence
	initial
	begin
		repeat (80000) @(posedge clock_i);
		miscompares++;
		summarize();
	end

endmodule : voice_pcm_serial_port_tb_top
